// file: logic/rwk_pins.sv
// wake-key, interrupt request and ram-wipe pin logic of the clock chip
//
// Behaviour
// - without main supply, a wake-key fall requests system power-on
// - power-on needs battery enable, wake-key enable and auxiliary supply
// - with main supply present, low wake-key level raises an interrupt flag
// - interrupt request held low while any enabled status flag is set
// - enabled ram-wipe fall writes ones into all 242 user bytes
// - ram wipe works with or without main supply
module rwk_pins #(
  parameter int DebounceCycles = rwk_pkg::DEBOUNCE_CYC
) (
  input  wire logic                       clock,          // 200 MHz clock
  input  wire logic                       rst_n,          // async reset
  input  wire logic                       clkEn,          // clock enable
  input  wire logic                       mainSupply,     // main supply ok
  input  wire logic                       auxiliarySupply, // aux supply ok
  input  wire logic                       wakeKeyInputN,  // wake key pin
  input  wire logic                       ramWipeInputN,  // wipe pin
  output logic                            irqReqOut,      // irq pin level
  output logic                            irqReqOe,       // irq pin drive
  output logic                            powerOnReq,     // power switch on
  input  wire logic [rwk_pkg::ADDR_W-1:0] regAddr,        // register addr
  input  wire logic [rwk_pkg::DATA_W-1:0] regWdata,       // write data
  input  wire logic                       regWr,          // write strobe
  input  wire logic                       regRd,          // read strobe
  output logic      [rwk_pkg::DATA_W-1:0] regRdata        // read data
);
  typedef struct packed {
    logic                       mainMeta;
    logic                       mainSeen;
    logic                       auxMeta;
    logic                       auxSeen;
    logic [rwk_pkg::EV_W-1:0]   ctrl;
    logic [rwk_pkg::EV_W-1:0]   status;
    logic [rwk_pkg::EV_W-1:0]   mask;
    logic                       powerOn;
    logic [rwk_pkg::DATA_W-1:0] readData;
  } rwk_top_s;

  rwk_top_s st;
  rwk_top_s next_st;

  logic                     rstMeta;
  logic                     rstN;
  logic                     keyLevel;
  logic                     keyFell;
  logic                     wipeLevel;
  logic                     wipeFell;
  logic                     kickArmed;
  logic [rwk_pkg::EV_W-1:0] events;
  logic [rwk_pkg::EV_W-1:0] clearBits;

  rwk_ram_if ramBus ();

  // true when the address falls in user ram
  function automatic logic isRam(input logic [rwk_pkg::ADDR_W-1:0] a);
    isRam = (a >= rwk_pkg::RAM_BASE);
  endfunction : isRam

  // ram byte index for a register address
  function automatic logic [rwk_pkg::ADDR_W-1:0] ramIndex(
    input logic [rwk_pkg::ADDR_W-1:0] a
  );
    ramIndex = a - rwk_pkg::RAM_BASE;
  endfunction : ramIndex

  // strobe aimed at one register address
  function automatic logic regHit(
    input logic                       strobe,
    input logic [rwk_pkg::ADDR_W-1:0] a,
    input logic [rwk_pkg::ADDR_W-1:0] target
  );
    regHit = strobe && (a == target);
  endfunction : regHit

  // reset release through two flops
  // assert is immediate, release waits for two enabled edges
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta <= 1'b0;
      rstN    <= 1'b0;
    end else if (clkEn) begin
      rstMeta <= 1'b1;
      rstN    <= rstMeta;
    end
  end

  rwk_filter #(
    .Cycles (DebounceCycles),
    .CountW (rwk_pkg::DEBOUNCE_W)
  ) keyFilter (
    .clock (clock),
    .rstN  (rstN),
    .clkEn (clkEn),
    .pinN  (wakeKeyInputN),
    .level (keyLevel),
    .fell  (keyFell)
  );

  rwk_filter #(
    .Cycles (DebounceCycles),
    .CountW (rwk_pkg::DEBOUNCE_W)
  ) wipeFilter (
    .clock (clock),
    .rstN  (rstN),
    .clkEn (clkEn),
    .pinN  (ramWipeInputN),
    .level (wipeLevel),
    .fell  (wipeFell)
  );

  // user ram and its wipe sequencer
  rwk_ram userRam (
    .clock (clock),
    .rstN  (rstN),
    .clkEn (clkEn),
    .bus   (ramBus)
  );

  // kickstart armed only with both enables and aux supply
  assign kickArmed = st.ctrl[rwk_pkg::CTRL_AUX_BAT]
                   & st.ctrl[rwk_pkg::CTRL_WAKE_EN]
                   & st.auxSeen;

  // wipe starts on enabled fall, main supply not consulted
  // falls during a running wipe are dropped, not queued
  assign ramBus.wipeReq = wipeFell & st.ctrl[rwk_pkg::CTRL_WIPE_EN]
                        & ~ramBus.wipeBusy;
  assign ramBus.addr    = ramIndex(regAddr);
  assign ramBus.wdata   = regWdata;
  assign ramBus.we      = regWr & isRam(regAddr);

  // event sources for the sticky status bits
  always_comb begin
    events = '0;
    // low key with main supply is an interrupt source
    events[rwk_pkg::EV_WAKE_KEY]  = ~keyLevel & st.mainSeen;
    events[rwk_pkg::EV_WIPE_DONE] = ramBus.wipeDone;
    // key fall without main supply is a power-on event
    events[rwk_pkg::EV_POWER_ON]  = keyFell & ~st.mainSeen & kickArmed;
  end

  // write-one-to-clear mask for status
  always_comb begin
    clearBits = '0;
    if (regHit(regWr, regAddr, rwk_pkg::ADDR_STATUS)) begin
      clearBits = regWdata[rwk_pkg::EV_W-1:0];
    end
  end

  // next state: supply sync, registers, power request, read data
  always_comb begin
    next_st          = st;
    next_st.mainMeta = mainSupply;
    next_st.mainSeen = st.mainMeta;
    next_st.auxMeta  = auxiliarySupply;
    next_st.auxSeen  = st.auxMeta;
    // host clears flags; a same-cycle event wins
    next_st.status   = (st.status & ~clearBits) | events;
    if (regHit(regWr, regAddr, rwk_pkg::ADDR_CTRL)) begin
      next_st.ctrl = regWdata[rwk_pkg::EV_W-1:0];
    end
    if (regHit(regWr, regAddr, rwk_pkg::ADDR_MASK)) begin
      next_st.mask = regWdata[rwk_pkg::EV_W-1:0];
    end
    // hold power-on until main supply returns
    if (st.mainSeen) begin
      next_st.powerOn = 1'b0;
    end else if (events[rwk_pkg::EV_POWER_ON]) begin
      next_st.powerOn = 1'b1;
    end
    // read data stands one cycle only
    next_st.readData = '0;
    if (regRd) begin
      if (isRam(regAddr)) begin
        next_st.readData = ramBus.rdata;
      end else begin
        case (regAddr)
          rwk_pkg::ADDR_CTRL:   next_st.readData = 8'(st.ctrl);
          rwk_pkg::ADDR_STATUS: next_st.readData = 8'(st.status);
          rwk_pkg::ADDR_MASK:   next_st.readData = 8'(st.mask);
          rwk_pkg::ADDR_STATE:  next_st.readData = {2'h0, st.mainSeen,
                                  st.auxSeen, keyLevel, wipeLevel,
                                  ramBus.wipeBusy, st.powerOn};
          default:              next_st.readData = '0;
        endcase
      end
    end
  end

  // state register
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      st <= '{mainMeta: 1'b0, mainSeen: 1'b0, auxMeta: 1'b0,
              auxSeen: 1'b0, ctrl: rwk_pkg::CTRL_RESET, status: '0,
              mask: rwk_pkg::MASK_RESET, powerOn: 1'b0, readData: '0};
    end else if (clkEn) begin
      st <= next_st;
    end
  end

  // open-drain request pulls low while enabled flag set
  // the pin only sinks; the host pull-up gives the idle high
  assign irqReqOut  = 1'b0;
  assign irqReqOe   = |(st.status & st.mask);
  assign powerOnReq = st.powerOn;
  assign regRdata   = st.readData;

  // armed key fall without main requests power-on
  a_power_on_set: assert property (@(posedge clock)
    disable iff (!rstN || !clkEn)
    (keyFell && !st.mainSeen && kickArmed) |=> powerOnReq)
    else $error("power-on not requested after wake-key fall");

  // request held until main supply is seen
  a_power_hold: assert property (@(posedge clock)
    disable iff (!rstN || !clkEn)
    (powerOnReq && !st.mainSeen) |=> powerOnReq)
    else $error("power-on request dropped before main supply");

  // request comes with its status flag
  a_power_flag: assert property (@(posedge clock)
    disable iff (!rstN || !clkEn)
    $rose(powerOnReq) |-> st.status[rwk_pkg::EV_POWER_ON])
    else $error("power-on raised without its status flag");

  a_power_gated: assert property (@(posedge clock)
    disable iff (!rstN || !clkEn)
    $rose(powerOnReq) |-> $past(kickArmed) && $past(keyFell))
    else $error("power-on raised without both enables and aux supply");

  // low key under main supply sets the flag
  a_key_flag: assert property (@(posedge clock)
    disable iff (!rstN || !clkEn)
    (!keyLevel && st.mainSeen) |=> st.status[rwk_pkg::EV_WAKE_KEY])
    else $error("wake-key low under main supply not flagged");

  // no key flag without main supply
  a_key_quiet: assert property (@(posedge clock)
    disable iff (!rstN || !clkEn)
    (!st.mainSeen && !st.status[rwk_pkg::EV_WAKE_KEY])
      |=> !st.status[rwk_pkg::EV_WAKE_KEY])
    else $error("wake-key flag set without main supply");

  // no power-on while main supply present
  a_no_kick_main: assert property (@(posedge clock)
    disable iff (!rstN || !clkEn)
    st.mainSeen |=> !powerOnReq)
    else $error("power-on asserted while main supply present");

  // enabled set flag keeps the request low over time
  a_irq_hold: assert property (@(posedge clock)
    disable iff (!rstN || !clkEn)
    (irqReqOe && !regWr) |=> irqReqOe)
    else $error("interrupt request released without a host write");

  // request drops only after a status or mask write
  a_irq_release: assert property (@(posedge clock)
    disable iff (!rstN || !clkEn)
    $fell(irqReqOe) |-> $past(regWr) &&
      ($past(regAddr) == rwk_pkg::ADDR_STATUS ||
       $past(regAddr) == rwk_pkg::ADDR_MASK))
    else $error("interrupt request fell with no clearing write");

  // set flags stay set without a write
  a_status_sticky: assert property (@(posedge clock)
    disable iff (!rstN || !clkEn)
    !regWr |=> (st.status & $past(st.status)) == $past(st.status))
    else $error("status flag dropped without a host write");

  // every event lands, also beside a clear
  a_event_lands: assert property (@(posedge clock)
    disable iff (!rstN || !clkEn)
    (|events) |=> (st.status & $past(events)) == $past(events))
    else $error("status event lost");

  a_status_w1c: assert property (@(posedge clock)
    disable iff (!rstN || !clkEn)
    regHit(regWr, regAddr, rwk_pkg::ADDR_STATUS) |=>
      ((st.status & ~$past(events)
        & $past(regWdata[rwk_pkg::EV_W-1:0])) == '0))
    else $error("written status ones did not clear");

  // enabled wipe fall starts the wipe next cycle
  a_wipe_start: assert property (@(posedge clock)
    disable iff (!rstN || !clkEn)
    (wipeFell && st.ctrl[rwk_pkg::CTRL_WIPE_EN] && !ramBus.wipeBusy)
      |=> ramBus.wipeBusy ##243 st.status[rwk_pkg::EV_WIPE_DONE])
    else $error("enabled ram wipe did not run to completion");

  // wipe end sets its status flag
  a_wipe_done_flag: assert property (@(posedge clock)
    disable iff (!rstN || !clkEn)
    ramBus.wipeDone |=> st.status[rwk_pkg::EV_WIPE_DONE])
    else $error("wipe end not flagged");

  a_wipe_gated: assert property (@(posedge clock)
    disable iff (!rstN || !clkEn)
    $rose(ramBus.wipeBusy) |-> $past(st.ctrl[rwk_pkg::CTRL_WIPE_EN]))
    else $error("ram wipe started while disabled");
endmodule : rwk_pins

// file: logic/rwk_pkg.sv
// constants shared by the wake-key, interrupt and ram-wipe pin logic
package rwk_pkg;
  // register port widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int EV_W   = 3;

  // register offsets, user ram fills the space from RAM_BASE to the top
  localparam logic [ADDR_W-1:0] ADDR_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h01;
  localparam logic [ADDR_W-1:0] ADDR_MASK   = 8'h02;
  localparam logic [ADDR_W-1:0] ADDR_STATE  = 8'h03;
  localparam logic [ADDR_W-1:0] RAM_BASE    = 8'h0e;
  localparam int                RAM_BYTES   = 242;
  localparam logic [ADDR_W-1:0] RAM_LAST    = 8'(RAM_BYTES - 1);
  localparam logic [DATA_W-1:0] WIPE_VALUE  = 8'hff;

  // control bits
  localparam int CTRL_AUX_BAT  = 0;
  localparam int CTRL_WAKE_EN  = 1;
  localparam int CTRL_WIPE_EN  = 2;
  // status and mask bits
  localparam int EV_WAKE_KEY   = 0;
  localparam int EV_WIPE_DONE  = 1;
  localparam int EV_POWER_ON   = 2;
  localparam logic [EV_W-1:0] CTRL_RESET = 3'h0;
  localparam logic [EV_W-1:0] MASK_RESET = 3'h0;

  // switch debounce time and its cycle count at 200 MHz
  localparam int CLK_PERIOD_PS = 5000;
  localparam int DEBOUNCE_US   = 2000;
  localparam int DEBOUNCE_CYC  = DEBOUNCE_US * (1000000 / CLK_PERIOD_PS);
  localparam int DEBOUNCE_W    = 20;

  // wipe sequencer states
  typedef enum logic [1:0] {
    WIPE_IDLE = 2'b01,
    WIPE_RUN  = 2'b10
  } rwk_wipe_e;
endpackage : rwk_pkg

// file: logic/rwk_ram_if.sv
// link between the pin logic and the user ram with its wipe sequencer
interface rwk_ram_if;
  logic [rwk_pkg::ADDR_W-1:0] addr;      // ram byte index
  logic [rwk_pkg::DATA_W-1:0] wdata;     // write byte
  logic                       we;        // write strobe
  logic [rwk_pkg::DATA_W-1:0] rdata;     // byte at addr
  logic                       wipeReq;   // start a wipe
  logic                       wipeBusy;  // wipe in progress
  logic                       wipeDone;  // pulse at wipe end

  modport ctl (output addr, wdata, we, wipeReq,
               input  rdata, wipeBusy, wipeDone);
  modport mem (input  addr, wdata, we, wipeReq,
               output rdata, wipeBusy, wipeDone);
endinterface : rwk_ram_if

// file: logic/rwk_filter.sv
// two-flop synchroniser and debounce filter for a switch pin
module rwk_filter #(
  parameter int Cycles = rwk_pkg::DEBOUNCE_CYC,
  parameter int CountW = rwk_pkg::DEBOUNCE_W
) (
  input  wire logic clock,  // core clock
  input  wire logic rstN,   // synchronised reset, active low
  input  wire logic clkEn,  // freezes state while low
  input  wire logic pinN,   // raw switch pin, active low
  output logic      level,  // debounced level
  output logic      fell    // one-cycle pulse on a debounced fall
);
  localparam logic [CountW-1:0] LastCount = CountW'(Cycles - 1);

  typedef struct packed {
    logic              meta;
    logic              seen;
    logic              stable;
    logic              fell;
    logic [CountW-1:0] count;
  } rwk_filt_s;

  rwk_filt_s st;
  rwk_filt_s next_st;

  always_comb begin
    next_st      = st;
    next_st.meta = pinN;
    next_st.seen = st.meta;
    next_st.fell = 1'b0;
    if (st.seen == st.stable) begin
      next_st.count = '0;
    end else if (st.count == LastCount) begin
      next_st.stable = st.seen;
      next_st.count  = '0;
      next_st.fell   = ~st.seen;
    end else begin
      next_st.count = st.count + 1'b1;
    end
  end

  // state register, idle pin reads high
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      st <= '{meta: 1'b1, seen: 1'b1, stable: 1'b1, fell: 1'b0, count: '0};
    end else if (clkEn) begin
      st <= next_st;
    end
  end

  assign level = st.stable;
  assign fell  = st.fell;

  // level moves only after full count
  a_filter_hold: assert property (@(posedge clock)
    disable iff (!rstN)
    $changed(st.stable) |-> $past(st.count) == LastCount)
    else $error("debounced level moved before the filter time");
endmodule : rwk_filter

// file: logic/rwk_ram.sv
// 242-byte user ram with a sequencer that fills it with ones
module rwk_ram (
  input wire logic clock,  // core clock
  input wire logic rstN,   // synchronised reset, active low
  input wire logic clkEn,  // freezes state while low
  rwk_ram_if.mem   bus     // access and wipe control
);
  typedef struct packed {
    rwk_pkg::rwk_wipe_e         state;
    logic [rwk_pkg::ADDR_W-1:0] ptr;
    logic                       done;
  } rwk_ram_s;

  logic [rwk_pkg::DATA_W-1:0] mem [rwk_pkg::RAM_BYTES];
  rwk_ram_s st;
  rwk_ram_s next_st;

  // walk every byte once per wipe
  always_comb begin
    next_st      = st;
    next_st.done = 1'b0;
    case (st.state)
      rwk_pkg::WIPE_IDLE: begin
        if (bus.wipeReq) begin
          next_st.state = rwk_pkg::WIPE_RUN;
          next_st.ptr   = '0;
        end
      end
      rwk_pkg::WIPE_RUN: begin
        next_st.ptr = st.ptr + 1'b1;
        if (st.ptr == rwk_pkg::RAM_LAST) begin
          next_st.state = rwk_pkg::WIPE_IDLE;
          next_st.done  = 1'b1;
        end
      end
      default: next_st.state = rwk_pkg::WIPE_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      st <= '{state: rwk_pkg::WIPE_IDLE, ptr: '0, done: 1'b0};
    end else if (clkEn) begin
      st <= next_st;
    end
  end

  // wipe writes win, bus writes during a wipe are dropped
  always_ff @(posedge clock) begin
    if (clkEn) begin
      if (st.state == rwk_pkg::WIPE_RUN) begin
        mem[st.ptr] <= rwk_pkg::WIPE_VALUE;
      end else if (bus.we && bus.addr <= rwk_pkg::RAM_LAST) begin
        mem[bus.addr] <= bus.wdata;
      end
    end
  end

  assign bus.rdata    = (bus.addr <= rwk_pkg::RAM_LAST) ? mem[bus.addr] : '0;
  assign bus.wipeBusy = (st.state == rwk_pkg::WIPE_RUN);
  assign bus.wipeDone = st.done;

  a_wipe_length: assert property (@(posedge clock)
    disable iff (!rstN || !clkEn)
    $rose(bus.wipeBusy) |-> ##241 bus.wipeBusy ##1 !bus.wipeBusy)
    else $error("wipe did not cover exactly all user bytes");

  a_wipe_value: assert property (@(posedge clock)
    disable iff (!rstN || !clkEn)
    bus.wipeBusy |=> mem[$past(st.ptr)] == rwk_pkg::WIPE_VALUE)
    else $error("wiped byte does not read all ones");
endmodule : rwk_ram

// file: verif/rwk_host_model.sv
// host side model: pulled-up interrupt wire and system power switch
module rwk_host_model #(
  parameter int PowerDelay = 4
) (
  input  wire logic clock,       // core clock
  input  wire logic rstN,        // reset, active low
  input  wire logic mainOn,      // bench applies main supply
  input  wire logic mainDrop,    // bench opens the power switch
  input  wire logic irqReqOut,   // irq pin value
  input  wire logic irqReqOe,    // irq pin drive
  input  wire logic powerOnReq,  // power-on request
  output logic      irqLineN,    // irq wire level
  output logic      mainSupply   // main supply seen by the chip
);
  timeunit 1ns;
  timeprecision 100ps;
  logic switched;
  int   dly;

  // open-drain wire, pull-up wins when nobody drives
  assign irqLineN = irqReqOe ? irqReqOut : 1'b1;
  assign mainSupply = mainOn | switched;

  // switch closes a while after a steady request
  always @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      switched <= 1'b0;
      dly <= 0;
    end else if (mainDrop) begin
      switched <= 1'b0;
      dly <= 0;
    end else if (powerOnReq) begin
      dly <= dly + 1;
      if (dly >= PowerDelay - 1) begin
        switched <= 1'b1;
      end
    end else begin
      dly <= 0;
    end
  end
endmodule : rwk_host_model

// file: verif/rwk_pins_test.sv
// self-checking bench for the wake-key, interrupt and ram-wipe pins
module rwk_pins_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic                       clock;
  logic                       rst_n;
  logic                       mainOn;
  logic                       mainDrop;
  logic                       mainSupply;
  logic                       auxiliarySupply;
  logic                       wakeKeyInputN;
  logic                       ramWipeInputN;
  logic                       irqReqOut;
  logic                       irqReqOe;
  logic                       irqLineN;
  logic                       powerOnReq;
  logic                       regWr;
  logic                       regRd;
  logic [rwk_pkg::ADDR_W-1:0] regAddr;
  logic [rwk_pkg::DATA_W-1:0] regWdata;
  logic [rwk_pkg::DATA_W-1:0] regRdata;
  int                         fails;
  int                         checks;

  rwk_pins #(.DebounceCycles(4)) rwk_pins_inst (
    .clock(clock), .rst_n(rst_n), .clkEn(1'b1), .mainSupply(mainSupply),
    .auxiliarySupply(auxiliarySupply), .wakeKeyInputN(wakeKeyInputN),
    .ramWipeInputN(ramWipeInputN), .irqReqOut(irqReqOut),
    .irqReqOe(irqReqOe), .powerOnReq(powerOnReq), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata));

  rwk_host_model rwk_host_model_inst (
    .clock(clock), .rstN(rst_n), .mainOn(mainOn), .mainDrop(mainDrop),
    .irqReqOut(irqReqOut), .irqReqOe(irqReqOe), .powerOnReq(powerOnReq),
    .irqLineN(irqLineN), .mainSupply(mainSupply));

  // 200 MHz clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic final_report;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk1

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= v;
    @(posedge clock);
    regWr <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clock);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRd <= 1'b0;
    #1;
    v = regRdata;
  endtask : rd

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk8(v, exp);
  endtask : rdchk

  // switch held low for n cycles, then left to settle
  task automatic press(input bit wipe, input int n);
    @(posedge clock);
    if (wipe) begin
      ramWipeInputN <= 1'b0;
    end else begin
      wakeKeyInputN <= 1'b0;
    end
    repeat (n) @(posedge clock);
    ramWipeInputN <= 1'b1;
    wakeKeyInputN <= 1'b1;
    repeat (12) @(posedge clock);
  endtask : press

  task automatic drop_main;
    @(posedge clock);
    mainOn <= 1'b0;
    mainDrop <= 1'b1;
    @(posedge clock);
    mainDrop <= 1'b0;
  endtask : drop_main

  task automatic t_reset;
    rdchk(rwk_pkg::ADDR_CTRL, 8'h00);
    rdchk(rwk_pkg::ADDR_MASK, 8'h00);
    rdchk(rwk_pkg::ADDR_STATE, 8'h0c);
    wr(8'h05, 8'hff);
    rdchk(8'h05, 8'h00);
    chk1(irqLineN, 1'b1);
  endtask : t_reset

  task automatic t_key_irq;
    mainOn <= 1'b1;
    auxiliarySupply <= 1'b1;
    wr(rwk_pkg::ADDR_CTRL, 8'h03);
    wr(rwk_pkg::ADDR_MASK, 8'h01);
    press(1'b0, 2);
    rdchk(rwk_pkg::ADDR_STATUS, 8'h00);
    press(1'b0, 20);
    rdchk(rwk_pkg::ADDR_STATUS, 8'h01);
    chk1(powerOnReq, 1'b0);
    chk1(irqLineN, 1'b0);
    wr(rwk_pkg::ADDR_MASK, 8'h00);
    repeat (2) @(posedge clock);
    #1;
    chk1(irqLineN, 1'b1);
    wr(rwk_pkg::ADDR_MASK, 8'h01);
    repeat (2) @(posedge clock);
    #1;
    chk1(irqLineN, 1'b0);
    wr(rwk_pkg::ADDR_STATUS, 8'h01);
    rdchk(rwk_pkg::ADDR_STATUS, 8'h00);
    chk1(irqLineN, 1'b1);
  endtask : t_key_irq

  task automatic t_power_on;
    logic [7:0] ctl [4] = '{8'h02, 8'h01, 8'h03, 8'h03};
    logic       aux [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
    for (int i = 0; i < 4; i++) begin
      drop_main();
      auxiliarySupply <= aux[i];
      wr(rwk_pkg::ADDR_CTRL, ctl[i]);
      press(1'b0, 20);
      rdchk(rwk_pkg::ADDR_STATUS, (i == 3) ? 8'h05 : 8'h00);
      chk1(mainSupply, i == 3);
      chk1(powerOnReq, 1'b0);
      wr(rwk_pkg::ADDR_STATUS, 8'h07);
    end
  endtask : t_power_on

  task automatic t_wipe;
    logic [7:0] v;
    drop_main();
    wr(rwk_pkg::RAM_BASE, 8'h5a);
    wr(8'hff, 8'ha5);
    wr(rwk_pkg::ADDR_CTRL, 8'h00);
    press(1'b1, 20);
    rdchk(rwk_pkg::RAM_BASE, 8'h5a);
    rdchk(8'hff, 8'ha5);
    wr(rwk_pkg::ADDR_MASK, 8'h02);
    wr(rwk_pkg::ADDR_CTRL, 8'h04);
    press(1'b1, 20);
    // poll for the done flag with a bound
    for (int n = 0; n < 300; n++) begin
      rd(rwk_pkg::ADDR_STATUS, v);
      if (v[rwk_pkg::EV_WIPE_DONE] === 1'b1) begin
        break;
      end
    end
    rdchk(rwk_pkg::ADDR_STATUS, 8'h02);
    chk1(irqLineN, 1'b0);
    for (int a = 0; a < rwk_pkg::RAM_BYTES; a++) begin
      rdchk(8'(rwk_pkg::RAM_BASE + a), rwk_pkg::WIPE_VALUE);
    end
  endtask : t_wipe

  // main sequence
  initial begin
    fails = 0;
    checks = 0;
    rst_n = 1'b0;
    mainOn = 1'b0;
    mainDrop = 1'b0;
    auxiliarySupply = 1'b0;
    wakeKeyInputN = 1'b1;
    ramWipeInputN = 1'b1;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 8'h00;
    regWdata = 8'h00;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    t_reset();
    t_key_irq();
    t_power_on();
    t_wipe();
    final_report();
  end

  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    final_report();
  end
endmodule : rwk_pins_test
